/* File: verilog/dma_pkg.sv */
// Shared constants, register map and carrier types of the descriptor DMA channel
package dma_pkg;
  // Register bus geometry
  localparam int ADDR_W = 6;
  localparam logic [ADDR_W-1:0] OFF_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFF_UPPER = 6'h04;
  localparam logic [ADDR_W-1:0] OFF_SWREQ = 6'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 6'h0c;
  localparam logic [ADDR_W-1:0] OFF_INT_STAT = 6'h10;
  localparam logic [ADDR_W-1:0] OFF_INT_MASK = 6'h14;
  localparam logic [ADDR_W-1:0] OFF_DESC_ADDR = 6'h18;
  localparam logic [ADDR_W-1:0] OFF_DESC_CTRL = 6'h1c;
  localparam logic [ADDR_W-1:0] OFF_DESC_COMMIT = 6'h20;
  // Channel control fields
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_PER_BURST = 1;
  localparam int CTRL_PRESERVE = 2;
  localparam int CTRL_BURST_LSB = 3;
  localparam int CTRL_FIRST_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h00000000;
  localparam logic [31:0] CTRL_MASK = 32'h0000ff1f;
  // Upper address halves
  localparam int UP_SRC_LSB = 0;
  localparam int UP_DST_LSB = 16;
  localparam logic [31:0] UPPER_RESET = 32'h00000000;
  // Descriptor staging fields
  localparam int DC_NEXT_LSB = 16;
  localparam int DC_INC_SRC = 24;
  localparam int DC_INC_DST = 25;
  localparam int DC_CMP_EN = 26;
  localparam logic [31:0] DC_MASK = 32'h07ffffff;
  localparam logic [31:0] STAGE_RESET = 32'h00000000;
  // Interrupt bits
  localparam int IRQ_W = 2;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_END = 1;
  // Descriptor table
  localparam int TD_DEPTH = 128;
  localparam int TD_IDX_W = 7;
  localparam logic [7:0] TD_TERMINATE = 8'hfe;
  // Completion pulse width in bus clocks
  localparam logic [1:0] PULSE_CYCLES = 2'h2;
  // AXI responses
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0] next;
    logic cmp_en;
    logic inc_dst;
    logic inc_src;
    logic [15:0] src_lo;
    logic [15:0] dst_lo;
  } desc_s;

  typedef struct packed {
    logic req;
    logic we;
    logic [2:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  // True for an aligned address inside the register map
  function automatic logic reg_mapped(input logic [ADDR_W-1:0] a);
    reg_mapped = (a[1:0] == 2'h0) && (a <= OFF_DESC_COMMIT);
  endfunction

  // Byte-lane merge under AXI write strobes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      wmerge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction
endpackage

/* File: verilog/desc_mem.sv */
// Descriptor table memory with registered read data
`timescale 1ns/100ps
module desc_mem (
  input wire logic aclk,
  input wire logic ce,
  input wire logic we,
  input wire logic [dma_pkg::TD_IDX_W-1:0] waddr,
  input wire dma_pkg::desc_s wdata,
  input wire logic [dma_pkg::TD_IDX_W-1:0] raddr,
  output dma_pkg::desc_s rdata
);
  import dma_pkg::*;
  desc_s mem [TD_DEPTH];

  // Write-first is not needed: reads see a write one edge later
  always_ff @(posedge aclk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule // desc_mem

/* File: verilog/axil_slave.sv */
// AXI4-Lite slave that turns bus transfers into register strobes
`timescale 1ns/100ps
module axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic awvalid,
  output logic awready,
  input wire logic [dma_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [dma_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic wr_en,
  output logic [dma_pkg::ADDR_W-1:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  output logic [dma_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [31:0] rd_data
);
  import dma_pkg::*;
  logic aw_full, w_full;

  // Register strobe fires once both halves of a write are held
  assign wr_en = aw_full && w_full;
  assign rd_addr = araddr;

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      wready <= 1'b1;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      bvalid <= 1'b0;
      bresp <= AXI_OKAY;
      wr_addr <= '0;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        awready <= 1'b0;
        aw_full <= 1'b1;
        wr_addr <= awaddr;
      end
      if (wvalid && wready) begin
        wready <= 1'b0;
        w_full <= 1'b1;
        wr_data <= wdata;
        wr_strb <= wstrb;
      end
      if (wr_en) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= reg_mapped(wr_addr) ? AXI_OKAY : AXI_SLVERR;
      end
      // Ready drops until the response is taken: one write at a time
      if (bvalid && bready) begin
        bvalid <= 1'b0;
        awready <= 1'b1;
        wready <= 1'b1;
      end
    end
  end

  // Read channel: data sampled at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= AXI_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_data;
        rresp <= reg_mapped(araddr) ? AXI_OKAY : AXI_SLVERR;
      end
      if (rvalid && rready) begin
        rvalid <= 1'b0;
        arready <= 1'b1;
      end
    end
  end
endmodule // axil_slave

/* File: verilog/dma_channel_descriptor_engine.sv */
// Descriptor-chained DMA channel engine with AXI4-Lite registers
// How it works
// [RULE_01] Address is channel upper 16 bits joined with descriptor lower 16 bits.
// [RULE_02] Burst count sets bytes read from source then written to destination.
// [RULE_03] Bursts up to four bytes, assuming 32-bit source and destination paths.
// [RULE_04] With request-per-burst set, each request runs exactly one burst.
// [RULE_05] With request-per-burst clear, one request runs bursts until count is zero.
// [RULE_06] After each burst, enabled addresses advance by the burst size.
// [RULE_07] After each burst, count drops by burst size; zero ends the transaction.
// [RULE_08] At count zero with completion enable set, a done pulse is emitted.
// [RULE_09] Next pointer 0xfe ends the chain after the current transaction.
// [RULE_10] A self-pointing descriptor reruns on later requests.
// [RULE_11] A software request register starts a transaction like a trigger.
// [RULE_12] Other channels may be served only between bursts, never inside one.
// [RULE_13] Preserve set keeps the original descriptor for reuse after completion.
// [RULE_14] The done pulse lasts exactly two bus clocks.
// [RULE_15] A short final burst moves only the remaining bytes.
`timescale 1ns/100ps
module dma_channel_descriptor_engine (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic hw_trigger,
  input wire logic hold_off,
  input wire logic awvalid,
  output logic awready,
  input wire logic [dma_pkg::ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [dma_pkg::ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output dma_pkg::mem_req_s mem_out,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ack,
  output logic done_pulse,
  output logic irq
);
  import dma_pkg::*;

  typedef enum {ST_IDLE, ST_FETCH, ST_LOAD, ST_WAIT, ST_GAP, ST_READ, ST_WRITE, ST_DONE,
                ST_STOP} state_e;

  state_e state;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [ADDR_W-1:0] rd_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_data;
  logic [3:0] wr_strb;
  logic [31:0] ctrl;
  logic [31:0] upper;
  logic [31:0] stage_addr;
  logic [31:0] stage_ctrl;
  logic [IRQ_W-1:0] int_stat;
  logic [IRQ_W-1:0] int_mask;
  logic [IRQ_W-1:0] int_evt;
  logic commit_pend;
  logic [TD_IDX_W-1:0] commit_idx;
  logic trig_s1, trig_s2, trig_s3;
  logic trig_edge, sw_req, req_pend, req_take;
  logic [7:0] td;
  desc_s work, mem_rd, mem_wd, stage_desc;
  logic mem_we, wb_now, busy, last;
  logic [TD_IDX_W-1:0] mem_waddr;
  logic [2:0] burst, bytes;
  logic [1:0] pulse_cnt;

  axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awvalid(awvalid),
    .awready(awready),
    .awaddr(awaddr),
    .wvalid(wvalid),
    .wready(wready),
    .wdata(wdata),
    .wstrb(wstrb),
    .bvalid(bvalid),
    .bready(bready),
    .bresp(bresp),
    .arvalid(arvalid),
    .arready(arready),
    .araddr(araddr),
    .rvalid(rvalid),
    .rready(rready),
    .rdata(rdata),
    .rresp(rresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  desc_mem u_table (
    .aclk(aclk),
    .ce(ce),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wd),
    .raddr(td[TD_IDX_W-1:0]),
    .rdata(mem_rd)
  );

  // Burst sizing: a short remainder trims the last burst
  assign burst = {1'b0, ctrl[CTRL_BURST_LSB +: 2]} + 3'h1; // [RULE_02] [RULE_03]
  assign last = work.count <= {13'h0, burst};
  assign bytes = last ? work.count[2:0] : burst; // [RULE_15]
  assign busy = (state != ST_IDLE) && (state != ST_STOP);

  // Request sources: synchronised trigger edge or a software write
  assign trig_edge = trig_s2 && !trig_s3;
  assign sw_req = wr_en && (wr_addr == OFF_SWREQ) && wr_strb[0] && wr_data[0]; // [RULE_11]
  assign req_take = (state == ST_WAIT) && ctrl[CTRL_ENABLE] && req_pend;

  // Table write port: engine write-back beats a staged commit
  assign wb_now = (state == ST_DONE) && !ctrl[CTRL_PRESERVE]; // [RULE_13]
  assign stage_desc = {stage_ctrl[15:0], stage_ctrl[DC_NEXT_LSB +: 8], stage_ctrl[DC_CMP_EN],
                       stage_ctrl[DC_INC_DST], stage_ctrl[DC_INC_SRC], stage_addr[15:0],
                       stage_addr[31:16]};
  assign mem_we = wb_now || commit_pend;
  assign mem_wd = wb_now ? work : stage_desc;
  assign mem_waddr = wb_now ? td[TD_IDX_W-1:0] : commit_idx;

  assign int_evt[IRQ_DONE] = (state == ST_DONE);
  assign int_evt[IRQ_END] = (state == ST_DONE) && (work.next == TD_TERMINATE);

  // Trigger pin crosses in through two flops; a third finds the edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1 <= 1'b0;
      trig_s2 <= 1'b0;
      trig_s3 <= 1'b0;
    end else if (ce) begin
      trig_s1 <= hw_trigger;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end

  // Pending request; a new one arriving as the old is taken survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      req_pend <= 1'b0;
    end else if (ce) begin
      if (trig_edge || sw_req) begin
        req_pend <= 1'b1; // [RULE_11]
      end else if (req_take) begin
        req_pend <= 1'b0;
      end
    end
  end

  // Software-written configuration and descriptor staging
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
      upper <= UPPER_RESET;
      stage_addr <= STAGE_RESET;
      stage_ctrl <= STAGE_RESET;
      int_mask <= '0;
      commit_pend <= 1'b0;
      commit_idx <= '0;
    end else if (ce) begin
      if (commit_pend && !wb_now) begin
        commit_pend <= 1'b0;
      end
      if (wr_en) begin
        case (wr_addr)
          OFF_CTRL: ctrl <= wmerge(ctrl, wr_data, wr_strb) & CTRL_MASK;
          OFF_UPPER: upper <= wmerge(upper, wr_data, wr_strb);
          OFF_INT_MASK: int_mask <= wr_strb[0] ? wr_data[IRQ_W-1:0] : int_mask;
          OFF_DESC_ADDR: stage_addr <= wmerge(stage_addr, wr_data, wr_strb);
          OFF_DESC_CTRL: stage_ctrl <= wmerge(stage_ctrl, wr_data, wr_strb) & DC_MASK;
          OFF_DESC_COMMIT: begin
            commit_pend <= 1'b1;
            commit_idx <= wr_data[TD_IDX_W-1:0];
          end
          default: ;
        endcase
      end
    end
  end

  // Sticky status, write one to clear; a same-cycle event wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_stat <= '0;
      irq <= 1'b0;
    end else if (ce) begin
      if (wr_en && (wr_addr == OFF_INT_STAT) && wr_strb[0]) begin
        int_stat <= (int_stat & ~wr_data[IRQ_W-1:0]) | int_evt;
      end else begin
        int_stat <= int_stat | int_evt;
      end
      irq <= |(int_stat & int_mask);
    end
  end

  // Register read mux; the slave registers the result
  always_comb begin
    case (rd_addr)
      OFF_CTRL: rd_data = ctrl;
      OFF_UPPER: rd_data = upper;
      OFF_STATUS: rd_data = {work.count, td, 7'h00, busy};
      OFF_INT_STAT: rd_data = {30'h0, int_stat};
      OFF_INT_MASK: rd_data = {30'h0, int_mask};
      OFF_DESC_ADDR: rd_data = stage_addr;
      OFF_DESC_CTRL: rd_data = stage_ctrl;
      default: rd_data = 32'h00000000;
    endcase
  end

  // Channel sequencer: fetch descriptor, wait request, run bursts, chain
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      td <= 8'h00;
      work <= '0;
      mem_out <= '0;
    end else if (ce) begin
      case (state)
        ST_IDLE: begin
          if (ctrl[CTRL_ENABLE]) begin
            td <= ctrl[CTRL_FIRST_LSB +: 8];
            state <= ST_FETCH;
          end
        end
        ST_FETCH: state <= ST_LOAD;
        ST_LOAD: begin
          work <= mem_rd;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (!ctrl[CTRL_ENABLE]) begin
            state <= ST_IDLE;
          end else if (req_pend) begin
            state <= (work.count == 16'h0) ? ST_DONE : ST_READ; // [RULE_04] [RULE_05]
          end
        end
        ST_GAP: begin
          // Bus handed to other channels only here, between bursts
          if (!ctrl[CTRL_ENABLE]) begin
            state <= ST_IDLE;
          end else if (!hold_off) begin
            state <= ST_READ; // [RULE_12]
          end
        end
        ST_READ: begin
          if (!mem_out.req) begin
            mem_out.req <= 1'b1;
            mem_out.we <= 1'b0;
            mem_out.size <= bytes; // [RULE_02] [RULE_15]
            mem_out.addr <= {upper[UP_SRC_LSB +: 16], work.src_lo}; // [RULE_01]
          end else if (mem_ack) begin
            mem_out.we <= 1'b1;
            mem_out.addr <= {upper[UP_DST_LSB +: 16], work.dst_lo}; // [RULE_01]
            mem_out.wdata <= mem_rdata;
            state <= ST_WRITE;
          end
        end
        ST_WRITE: begin
          if (mem_ack) begin
            mem_out.req <= 1'b0;
            mem_out.we <= 1'b0;
            work.count <= work.count - {13'h0, bytes}; // [RULE_07]
            if (work.inc_src) begin
              work.src_lo <= work.src_lo + {13'h0, bytes}; // [RULE_06]
            end
            if (work.inc_dst) begin
              work.dst_lo <= work.dst_lo + {13'h0, bytes}; // [RULE_06]
            end
            if (last) begin
              state <= ST_DONE; // [RULE_07]
            end else if (ctrl[CTRL_PER_BURST]) begin
              state <= ST_WAIT; // [RULE_04]
            end else begin
              state <= ST_GAP; // [RULE_05]
            end
          end
        end
        ST_DONE: begin
          // Self pointer refetches the same entry, original if preserved
          if (work.next == TD_TERMINATE) begin
            state <= ST_STOP; // [RULE_09]
          end else begin
            td <= work.next; // [RULE_10]
            state <= ST_FETCH;
          end
        end
        ST_STOP: begin
          if (!ctrl[CTRL_ENABLE]) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Completion pulse, held for a fixed number of bus clocks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      done_pulse <= 1'b0;
      pulse_cnt <= 2'h0;
    end else if (ce) begin
      if ((state == ST_DONE) && work.cmp_en) begin
        done_pulse <= 1'b1; // [RULE_08]
        pulse_cnt <= PULSE_CYCLES - 2'h1; // [RULE_14]
      end else if (pulse_cnt != 2'h0) begin
        pulse_cnt <= pulse_cnt - 2'h1;
      end else begin
        done_pulse <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge aclk iff ce);
  endclocking
  default disable iff (!aresetn);

  sequence s_pulse2;
    done_pulse ##1 done_pulse ##1 !done_pulse;
  endsequence

  property p_addr_form;
    (state == ST_READ) && !mem_out.req |=>
      mem_out.addr == {upper[UP_SRC_LSB +: 16], $past(work.src_lo)};
  endproperty
  a_addr_form: assert property (p_addr_form) else $error("source address not joined"); // [RULE_01]

  property p_size;
    mem_out.req |-> (mem_out.size <= 3'h4) && (mem_out.size != 3'h0);
  endproperty
  a_size: assert property (p_size) else $error("burst size out of range"); // [RULE_03]

  property p_per_burst;
    (state == ST_WRITE) && mem_ack && !last && ctrl[CTRL_PER_BURST] |=> state == ST_WAIT;
  endproperty
  a_per_burst: assert property (p_per_burst) else $error("burst ran without request"); // [RULE_04]

  property p_back_to_back;
    (state == ST_WRITE) && mem_ack && !last && !ctrl[CTRL_PER_BURST] |=> state == ST_GAP;
  endproperty
  a_back_to_back: assert property (p_back_to_back) else $error("chained burst lost"); // [RULE_05]

  property p_count;
    (state == ST_WRITE) && mem_ack |=> work.count == $past(work.count) - {13'h0, $past(bytes)};
  endproperty
  a_count: assert property (p_count) else $error("count not reduced by burst"); // [RULE_07]

  property p_no_inc;
    (state == ST_WRITE) && mem_ack && !work.inc_src |=> $stable(work.src_lo);
  endproperty
  a_no_inc: assert property (p_no_inc) else $error("source moved while disabled"); // [RULE_06]

  property p_done;
    (state == ST_DONE) && work.cmp_en |=> s_pulse2;
  endproperty
  a_done: assert property (p_done) else $error("done pulse not two clocks"); // [RULE_14]

  property p_term;
    (state == ST_DONE) && (work.next == TD_TERMINATE) |=> state == ST_STOP;
  endproperty
  a_term: assert property (p_term) else $error("chain ran past terminator"); // [RULE_09]

  property p_gap;
    (state == ST_GAP) && hold_off |=> (state != ST_READ) && (state != ST_WRITE) && !mem_out.req;
  endproperty
  a_gap: assert property (p_gap) else $error("burst started while held off"); // [RULE_12]
endmodule // dma_channel_descriptor_engine

/* File: verif/mem_model.sv */
// Behavioural memory and peripheral space that answers the engine's bus requests
`timescale 1ns/100ps
module mem_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire dma_pkg::mem_req_s mem_out,
  input wire logic [1:0] delay,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  import dma_pkg::*;
  logic [1:0] cnt;
  // Ack after delay idle cycles; read data depends only on the address.
  // Outside an ack the data toggles, so a stale sample never passes as a match.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt <= 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= 32'h0;
    end else if (mem_out.req && !mem_ack && cnt == delay) begin
      cnt <= 2'h0;
      mem_ack <= 1'b1;
      mem_rdata <= mem_out.addr ^ 32'h5a5a5a5a;
    end else begin
      cnt <= (mem_out.req && !mem_ack) ? cnt + 2'h1 : 2'h0;
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule // mem_model

/* File: verif/test_dma_channel_descriptor_engine.sv */
// Self-checking bench for the descriptor DMA channel engine
`timescale 1ns/100ps
module test_dma_channel_descriptor_engine;
  import dma_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic hw_trigger = 1'b0;
  logic hold_off = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] delay = 2'h0;
  logic awready, wready, bvalid, arready, rvalid, mem_ack, done_pulse, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, mem_rdata;
  mem_req_s mem_out;
  int fail_count = 0, checked = 0, pulses = 0;
  logic [31:0] wa[$], wd[$], ws[$];

  dma_channel_descriptor_engine i_dma_channel_descriptor_engine (
    .aclk(aclk), .aresetn(aresetn), .ce(1'b1), .hw_trigger(hw_trigger), .hold_off(hold_off),
    .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
    .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
    .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
    .rdata(rdata), .rresp(rresp), .mem_out(mem_out), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack), .done_pulse(done_pulse), .irq(irq));
  mem_model i_mem_model (.aclk(aclk), .aresetn(aresetn), .mem_out(mem_out), .delay(delay),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // Log each completed write and count completion-pulse cycles
  always @(posedge aclk) begin
    if (mem_out.req && mem_ack && mem_out.we) begin
      wa.push_back(mem_out.addr);
      wd.push_back(mem_out.wdata);
      ws.push_back({29'h0, mem_out.size});
    end
    if (done_pulse === 1'b1) pulses++;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data go out together; each drops once its own ready is seen
  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    check({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready && arvalid) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    check(rdata, exp);
    check({30'h0, rresp}, {30'h0, er});
  endtask

  task automatic wait_irq();
    for (int i = 0; i < 400 && irq !== 1'b1; i++) @(posedge aclk);
  endtask

  // Stage and commit one descriptor, then program the channel
  task automatic setup(input logic [31:0] up, ad, ct, input logic [6:0] ix,
                       input logic [31:0] cr);
    wr(OFF_UPPER, up, AXI_OKAY);
    wr(OFF_DESC_ADDR, ad, AXI_OKAY);
    wr(OFF_DESC_CTRL, ct, AXI_OKAY);
    wr(OFF_DESC_COMMIT, {25'h0, ix}, AXI_OKAY);
    wr(OFF_CTRL, cr, AXI_OKAY);
    wa = {};
    wd = {};
    ws = {};
    pulses = 0;
  endtask

  task automatic t_regs();
    check({30'h0, done_pulse, irq}, 32'h0);
    rd(OFF_CTRL, CTRL_RESET, AXI_OKAY);
    rd(OFF_UPPER, UPPER_RESET, AXI_OKAY);
    rd(6'h24, 32'h0, AXI_SLVERR);
    wr(6'h24, 32'h1, AXI_SLVERR);
    wr(OFF_DESC_CTRL, 32'hffffffff, AXI_OKAY);
    rd(OFF_DESC_CTRL, DC_MASK, AXI_OKAY);
    rd(OFF_SWREQ, 32'h0, AXI_OKAY);
    wr(OFF_INT_MASK, 32'h3, AXI_OKAY);
  endtask

  // Ten bytes in four-byte bursts, one software request, stalled between bursts
  task automatic t_copy();
    logic [31:0] m;
    hold_off <= 1'b1;
    setup(32'h22221111, 32'h02000100, 32'h07fe000a, 7'h03, 32'h00000319);
    wr(OFF_SWREQ, 32'h1, AXI_OKAY);
    repeat (30) @(posedge aclk);
    check(wa.size(), 1);
    hold_off <= 1'b0;
    wait_irq();
    check({31'h0, irq}, 32'h1);
    check(wa.size(), 3);
    for (int k = 0; k < 3; k++) begin
      m = (k < 2) ? 32'hffffffff : 32'h0000ffff;
      check(wa[k], 32'h22220200 + 4 * k);
      check(ws[k], (k < 2) ? 4 : 2);
      check(wd[k] & m, ((32'h11110100 + 4 * k) ^ 32'h5a5a5a5a) & m);
    end
    repeat (4) @(posedge aclk);
    check(pulses, 2);
    rd(OFF_INT_STAT, 32'h3, AXI_OKAY);
    rd(OFF_STATUS, 32'h00000300, AXI_OKAY);
    wr(OFF_SWREQ, 32'h1, AXI_OKAY);
    repeat (20) @(posedge aclk);
    check(wa.size(), 3);
    wr(OFF_INT_STAT, 32'h3, AXI_OKAY);
    rd(OFF_INT_STAT, 32'h0, AXI_OKAY);
    check({31'h0, irq}, 32'h0);
    wr(OFF_CTRL, 32'h0, AXI_OKAY);
  endtask

  // Self-linked preserved descriptor, one byte per trigger, slow memory
  task automatic t_loop();
    logic [31:0] s;
    delay <= 2'h2;
    setup(32'h44443333, 32'h00500010, 32'h01050002, 7'h05, 32'h00000507);
    // The request written while stopped is still pending, so one burst runs at once
    repeat (30) @(posedge aclk);
    check(wa.size(), 1);
    wa = {};
    wd = {};
    ws = {};
    for (int t = 0; t < 4; t++) begin
      hw_trigger <= 1'b1;
      repeat (3) @(posedge aclk);
      hw_trigger <= 1'b0;
      repeat (40) @(posedge aclk);
      s = 32'h33330011 - t % 2;
      check(wa.size(), t + 1);
      check(wa[t], 32'h44440050);
      check(wd[t] & 32'hff, (s ^ 32'h5a5a5a5a) & 32'hff);
      check(ws[t], 1);
    end
    check(pulses, 0);
    rd(OFF_STATUS, 32'h00010501, AXI_OKAY);
    rd(OFF_INT_STAT, 32'h1, AXI_OKAY);
    wr(OFF_INT_STAT, 32'h1, AXI_OKAY);
    wr(OFF_CTRL, 32'h0, AXI_OKAY);
    delay <= 2'h0;
  endtask

  task automatic give_verdict();
    if (fail_count == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    forever #2 aclk = ~aclk;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_copy();
    t_loop();
    give_verdict();
  end

  // A hang counts as a failure; the tests need well under this many cycles
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    give_verdict();
  end
endmodule // test_dma_channel_descriptor_engine
